// ### inc/rdq_pkg.sv
/*
  Constants, types and states of the receive descriptor queue.
  Assumes one clock domain and a 32-bit classic Wishbone slave port.
*/
// Overview of operation
// - Low pointer write pushes address, bumps count
// - Only the low pointer write queues anything
// - Fragments may start at any byte address
// - Post-receive header written back after packet
// - Fragment space exhausted: truncate, no error
// - Length field reached first: flag overflow
// - Length field at most 64 Kbytes
// - Descriptor size is 8 plus 16 per fragment
// - Request bit forces interrupt despite mask
// - Forced interrupt once, mask left untouched
// - Fragment entries follow header, read in order
// - Fragment length caps bytes written there
`default_nettype none
package rdq_pkg;
  localparam logic [7:0] REG_PTR_LO = 8'h00;
  localparam logic [7:0] REG_PTR_HI = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CLEAR = 8'h0C;
  localparam logic [7:0] REG_ENABLE = 8'h10;
  localparam logic [7:0] REG_QUEUE = 8'h14;
  localparam int ST_DONE = 0;
  localparam int ST_FORCED = 1;
  localparam int ST_OVF = 2;
  localparam int ST_QOVR = 3;
  localparam logic [3:0] ST_RESET = 4'h0;
  localparam logic [3:0] EN_RESET = 4'h0;
  localparam int IRQ_REQ_BIT = 31;
  localparam int FCNT_HI = 20;
  localparam int FCNT_LO = 16;
  localparam int LEN_HI = 15;
  localparam int POST_OVF_BIT = 27;
  localparam logic [31:0] HDR_BYTES = 32'h8;
  localparam logic [31:0] FRAG_LEN_OFS = 32'h8;
  localparam logic [16:0] LEN_MAX = 17'h10000;
  localparam int FIFO_DEPTH = 8;
  typedef struct packed {
    logic irq_req;
    logic [4:0] frag_count;
    logic [15:0] pkt_len;
  } rdq_hdr_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } rdq_mem_s;
  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_CHK, S_FADDR, S_FLEN, S_GET, S_PUT, S_DRAIN, S_WB, S_POST
  } rdq_state_e;
endpackage
`default_nettype wire

// ### design/rdq_top.sv
/*
  Receive descriptor queue: pointer FIFO, descriptor fetch, byte scatter,
  post-receive header write-back and interrupt status.
  Assumes a same-clock memory master handshake and a same-clock byte stream.
*/
`timescale 1ns/1ns
`default_nettype none
module rdq_top #(
  parameter int DEPTH = rdq_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Host memory master
  output logic M_REQ,
  output logic M_WE,
  output logic [31:0] M_ADDR,
  output logic [31:0] M_WDATA,
  output logic [3:0] M_BE,
  input wire logic [31:0] M_RDATA,
  input wire logic M_ACK,
  // Received byte stream
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_LAST,
  output logic RX_READY,
  // Interrupt
  output logic IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  function automatic rdq_pkg::rdq_mem_s mreq(input logic we, input logic [31:0] a,
                                             input logic [31:0] d, input logic [3:0] be);
    mreq = {1'b1, we, a, d, be};
  endfunction

  // Bus slave
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic wb_hit, wr_lo, wr_hi, wr_clr, wr_en;
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [31:0] fifo_mem [DEPTH];
  logic push, pop, full;
  logic [3:0] st_reg, st_next, en_reg, en_next, st_set, st_clr;
  logic irq_reg, irq_next;
  logic done_evt, forced_evt, ovf_evt;
  rdq_pkg::rdq_state_e state_reg, state_next;

  assign wb_hit = WB_CYC & WB_STB & ~ack_reg;
  assign wr_lo = wb_hit & WB_WE & (WB_ADR == rdq_pkg::REG_PTR_LO);
  assign wr_hi = wb_hit & WB_WE & (WB_ADR == rdq_pkg::REG_PTR_HI);
  assign wr_clr = wb_hit & WB_WE & (WB_ADR == rdq_pkg::REG_CLEAR);
  assign wr_en = wb_hit & WB_WE & (WB_ADR == rdq_pkg::REG_ENABLE) & WB_SEL[0];
  assign full = cnt_reg == CW'(DEPTH);
  assign push = wr_lo & ~full;

  always_comb begin
    ack_next = wb_hit;
    rdat_next = 32'h0;
    if (wb_hit && !WB_WE) begin
      case (WB_ADR)
        rdq_pkg::REG_STATUS: rdat_next = {28'h0, st_reg};
        rdq_pkg::REG_ENABLE: rdat_next = {28'h0, en_reg};
        rdq_pkg::REG_QUEUE: rdat_next = {state_reg != rdq_pkg::S_IDLE, 31'(cnt_reg)};
        default: rdat_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // Pointer FIFO; the high half of the pointer is accepted and dropped
  always_comb begin
    wp_next = wp_reg + AW'(push);
    rp_next = rp_reg + AW'(pop);
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      fifo_mem[wp_reg] <= {WB_DAT_I[31:3], 3'h0};
    end
  end

  // Interrupt status; a set in the clearing cycle wins
  always_comb begin
    st_set = 4'h0;
    st_set[rdq_pkg::ST_DONE] = done_evt;
    st_set[rdq_pkg::ST_FORCED] = forced_evt;
    st_set[rdq_pkg::ST_OVF] = ovf_evt;
    st_set[rdq_pkg::ST_QOVR] = wr_lo & full;
    st_clr = wr_clr ? WB_DAT_I[3:0] : 4'h0;
    st_next = (st_reg & ~st_clr) | st_set;
    en_next = wr_en ? WB_DAT_I[3:0] : en_reg;
    // Forced bit bypasses the enable register
    irq_next = (|(st_next & en_next)) | st_next[rdq_pkg::ST_FORCED];
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= rdq_pkg::ST_RESET;
      en_reg <= rdq_pkg::EN_RESET;
      irq_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      en_reg <= en_next;
      irq_reg <= irq_next;
    end
  end

  // Descriptor engine
  rdq_pkg::rdq_hdr_s hdr_reg, hdr_next;
  rdq_pkg::rdq_mem_s mem_reg, mem_next;
  logic [31:0] base_reg, base_next, faddr_reg, faddr_next, ent;
  logic [15:0] fleft_reg, fleft_next;
  logic [16:0] wr_cnt_reg, wr_cnt_next, limit;
  logic [4:0] idx_reg, idx_next;
  logic eop_reg, eop_next, by_len_reg, by_len_next, ovf_reg, ovf_next;
  logic rdy_reg, rdy_next;
  logic [31:0] post_word;

  // Zero length field means the full 64 Kbytes
  assign limit = (hdr_reg.pkt_len == 16'h0) ? rdq_pkg::LEN_MAX
                                            : {1'b0, hdr_reg.pkt_len};
  assign ent = base_reg + rdq_pkg::HDR_BYTES + {23'h0, idx_reg, 4'h0};
  always_comb begin
    post_word = 32'h0;
    post_word[rdq_pkg::LEN_HI:0] = wr_cnt_reg[15:0];
    post_word[rdq_pkg::FCNT_HI:rdq_pkg::FCNT_LO] = hdr_reg.frag_count;
    post_word[rdq_pkg::POST_OVF_BIT] = ovf_reg;
  end

  always_comb begin
    state_next = state_reg;
    hdr_next = hdr_reg;
    base_next = base_reg;
    faddr_next = faddr_reg;
    fleft_next = fleft_reg;
    wr_cnt_next = wr_cnt_reg;
    idx_next = idx_reg;
    eop_next = eop_reg;
    by_len_next = by_len_reg;
    ovf_next = ovf_reg;
    mem_next = mem_reg;
    if (M_ACK) begin
      mem_next.req = 1'b0;
    end
    pop = 1'b0;
    done_evt = 1'b0;
    forced_evt = 1'b0;
    ovf_evt = 1'b0;
    case (state_reg)
      rdq_pkg::S_IDLE: begin
        if (cnt_reg != '0) begin
          pop = 1'b1;
          base_next = fifo_mem[rp_reg];
          mem_next = mreq(1'b0, fifo_mem[rp_reg], 32'h0, 4'hF);
          state_next = rdq_pkg::S_HDR;
        end
      end
      rdq_pkg::S_HDR: begin
        if (M_ACK) begin
          hdr_next = {M_RDATA[rdq_pkg::IRQ_REQ_BIT],
                      M_RDATA[rdq_pkg::FCNT_HI:rdq_pkg::FCNT_LO],
                      M_RDATA[rdq_pkg::LEN_HI:0]};
          idx_next = 5'h0;
          fleft_next = 16'h0;
          wr_cnt_next = 17'h0;
          by_len_next = 1'b0;
          ovf_next = 1'b0;
          state_next = rdq_pkg::S_CHK;
        end
      end
      rdq_pkg::S_CHK: begin
        if (fleft_reg == 16'h0) begin
          if (idx_reg != hdr_reg.frag_count) begin
            mem_next = mreq(1'b0, ent, 32'h0, 4'hF);
            state_next = rdq_pkg::S_FADDR;
          end else begin
            state_next = rdq_pkg::S_DRAIN;
          end
        end else if (wr_cnt_reg == limit) begin
          by_len_next = 1'b1;
          state_next = rdq_pkg::S_DRAIN;
        end else begin
          state_next = rdq_pkg::S_GET;
        end
      end
      rdq_pkg::S_FADDR: begin
        if (M_ACK) begin
          faddr_next = M_RDATA;
          mem_next = mreq(1'b0, ent + rdq_pkg::FRAG_LEN_OFS, 32'h0, 4'hF);
          state_next = rdq_pkg::S_FLEN;
        end
      end
      rdq_pkg::S_FLEN: begin
        if (M_ACK) begin
          fleft_next = M_RDATA[15:0];
          idx_next = idx_reg + 5'h1;
          state_next = rdq_pkg::S_CHK;
        end
      end
      rdq_pkg::S_GET: begin
        if (RX_VALID && rdy_reg) begin
          mem_next = mreq(1'b1, {faddr_reg[31:2], 2'h0}, {4{RX_DATA}},
                          4'h1 << faddr_reg[1:0]);
          eop_next = RX_LAST;
          state_next = rdq_pkg::S_PUT;
        end
      end
      rdq_pkg::S_PUT: begin
        if (M_ACK) begin
          wr_cnt_next = wr_cnt_reg + 17'h1;
          fleft_next = fleft_reg - 16'h1;
          faddr_next = faddr_reg + 32'h1;
          state_next = eop_reg ? rdq_pkg::S_WB : rdq_pkg::S_CHK;
        end
      end
      rdq_pkg::S_DRAIN: begin
        if (RX_VALID && rdy_reg) begin
          if (by_len_reg) begin
            ovf_next = 1'b1;
          end
          if (RX_LAST) begin
            state_next = rdq_pkg::S_WB;
          end
        end
      end
      rdq_pkg::S_WB: begin
        mem_next = mreq(1'b1, base_reg, post_word, 4'hF);
        state_next = rdq_pkg::S_POST;
      end
      rdq_pkg::S_POST: begin
        if (M_ACK) begin
          done_evt = 1'b1;
          forced_evt = hdr_reg.irq_req;
          ovf_evt = ovf_reg;
          state_next = rdq_pkg::S_IDLE;
        end
      end
      default: state_next = rdq_pkg::S_IDLE;
    endcase
    rdy_next = (state_next == rdq_pkg::S_GET) || (state_next == rdq_pkg::S_DRAIN);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= rdq_pkg::S_IDLE;
      hdr_reg <= '0;
      base_reg <= 32'h0;
      faddr_reg <= 32'h0;
      fleft_reg <= 16'h0;
      wr_cnt_reg <= 17'h0;
      idx_reg <= 5'h0;
      eop_reg <= 1'b0;
      by_len_reg <= 1'b0;
      ovf_reg <= 1'b0;
      mem_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hdr_reg <= hdr_next;
      base_reg <= base_next;
      faddr_reg <= faddr_next;
      fleft_reg <= fleft_next;
      wr_cnt_reg <= wr_cnt_next;
      idx_reg <= idx_next;
      eop_reg <= eop_next;
      by_len_reg <= by_len_next;
      ovf_reg <= ovf_next;
      mem_reg <= mem_next;
      rdy_reg <= rdy_next;
    end
  end

  assign WB_ACK = ack_reg;
  assign WB_DAT_O = rdat_reg;
  assign M_REQ = mem_reg.req;
  assign M_WE = mem_reg.we;
  assign M_ADDR = mem_reg.addr;
  assign M_WDATA = mem_reg.wdata;
  assign M_BE = mem_reg.be;
  assign RX_READY = rdy_reg;
  assign IRQ = irq_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_post_done;
    state_reg == rdq_pkg::S_POST && M_ACK && hdr_reg.irq_req;
  endsequence

  a_push_count: assert property (
    wr_lo && !full && !pop |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("pointer write not counted");
  a_high_no_push: assert property (
    wr_hi |=> cnt_reg <= $past(cnt_reg))
    else $error("high pointer write queued");
  a_byte_lane: assert property (
    M_REQ && state_reg == rdq_pkg::S_PUT |->
    M_BE == (4'h1 << faddr_reg[1:0]) && M_WDATA[31:24] == M_WDATA[7:0])
    else $error("wrong byte lane");
  a_post_target: assert property (
    M_REQ && state_reg == rdq_pkg::S_POST |-> M_WE && M_ADDR == base_reg)
    else $error("post header misplaced");
  a_trunc_clean: assert property (
    state_reg == rdq_pkg::S_DRAIN && !by_len_reg |-> !ovf_reg)
    else $error("truncation flagged error");
  a_overflow_set: assert property (
    state_reg == rdq_pkg::S_DRAIN && by_len_reg && RX_VALID && RX_READY |=> ovf_reg)
    else $error("overflow not flagged");
  a_len_bound: assert property (
    state_reg == rdq_pkg::S_GET |-> wr_cnt_reg < limit)
    else $error("length bound passed");
  a_entry_addr: assert property (
    M_REQ && state_reg == rdq_pkg::S_FADDR |->
    M_ADDR - base_reg == {23'h0, idx_reg, 4'h0} + 32'h8)
    else $error("fragment entry address wrong");
  a_forced_irq: assert property (
    s_post_done |=> IRQ && st_reg[rdq_pkg::ST_FORCED])
    else $error("forced interrupt missing");
  a_mask_kept: assert property (
    forced_evt && !wr_en |=> en_reg == $past(en_reg))
    else $error("mask changed by forced interrupt");
  a_frag_space: assert property (
    state_reg == rdq_pkg::S_PUT |-> fleft_reg != 16'h0)
    else $error("fragment overrun");
endmodule
`default_nettype wire

// ### testbench/rdq_mem_model.sv
/*
  Host memory model that answers the engine's word requests.
  Assumes the engine holds each request until it sees the acknowledge.
*/
`timescale 1ns/1ns
`default_nettype none
module rdq_mem_model (
  // Clock
  input wire logic clk,
  // Request
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic [3:0] lat,
  // Answer
  output logic [31:0] rdata,
  output logic ack
);
  // Descriptors are aligned, zeroed and filled before their pointer is queued
  logic [31:0] mem [0:1023];
  logic [3:0] wait_cnt;
  initial begin
    ack = 1'b0;
    rdata = 32'h0;
    wait_cnt = 4'h0;
  end
  always @(posedge clk) begin
    if (req && !ack && wait_cnt < lat) begin
      wait_cnt <= wait_cnt + 4'h1;
      rdata <= ~rdata;
    end else if (req && !ack) begin
      ack <= 1'b1;
      wait_cnt <= 4'h0;
      rdata <= we ? ~rdata : mem[addr[11:2]];
      for (int b = 0; b < 4; b++) begin
        if (we && be[b]) begin
          mem[addr[11:2]][8*b +: 8] <= wdata[8*b +: 8];
        end
      end
    end else begin
      // Read data is not held once the answer is over
      ack <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule
`default_nettype wire

// ### testbench/rdq_top_bench.sv
/*
  Self-checking bench for the receive descriptor queue.
  Assumes the memory model answers the engine's master port.
*/
`timescale 1ns/1ns
`default_nettype none
module rdq_top_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, m_addr, m_wdata, m_rdata;
  logic ack, m_req, m_we, m_ack, rx_ready, irq;
  logic [3:0] m_be;
  logic [3:0] lat = 4'h0;
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [7:0] rx_data = 8'h00;
  int bad_count = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  rdq_top rdq_top_i (.CLK(clk), .SRST(srst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK(ack),
    .M_REQ(m_req), .M_WE(m_we), .M_ADDR(m_addr), .M_WDATA(m_wdata), .M_BE(m_be),
    .M_RDATA(m_rdata), .M_ACK(m_ack), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_LAST(rx_last), .RX_READY(rx_ready), .IRQ(irq));
  rdq_mem_model rdq_mem_model_i (.clk(clk), .req(m_req), .we(m_we), .addr(m_addr),
    .wdata(m_wdata), .be(m_be), .lat(lat), .rdata(m_rdata), .ack(m_ack));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timed_out;
    bad_count++;
    $display("[ERR] %0t wait limit reached", $time);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1) timed_out();
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Descriptor with two fragments; fragment area pre-filled with a guard pattern
  task automatic desc(input logic [31:0] p, input logic [31:0] hdr, input logic [31:0] fa0,
                      input logic [15:0] fl0, input logic [31:0] fa1, input logic [15:0] fl1);
    for (int i = 64; i < 192; i++) rdq_mem_model_i.mem[i] = 32'hA5A5A5A5;
    for (int i = 0; i < 10; i++) rdq_mem_model_i.mem[p[11:2] + i] = 32'h0;
    rdq_mem_model_i.mem[p[11:2]] = hdr;
    rdq_mem_model_i.mem[p[11:2] + 2] = fa0;
    rdq_mem_model_i.mem[p[11:2] + 4] = {16'h0, fl0};
    rdq_mem_model_i.mem[p[11:2] + 6] = fa1;
    rdq_mem_model_i.mem[p[11:2] + 8] = {16'h0, fl1};
  endtask
  task automatic send(input int nb, input logic [7:0] base);
    int n;
    for (int k = 0; k < nb; k++) begin
      rx_valid <= 1'b1;
      rx_data <= base + k[7:0];
      rx_last <= (k == nb - 1);
      n = 0;
      @(posedge clk);
      while (rx_ready !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      if (rx_ready !== 1'b1) timed_out();
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  task automatic wait_done;
    logic [31:0] q;
    q = 32'h0;
    for (int i = 0; i < 100 && q[0] !== 1'b1; i++) wb(1'b0, rdq_pkg::REG_STATUS, 32'h0, q);
    if (q[0] !== 1'b1) timed_out();
  endtask
  task automatic bytes_chk(input logic [31:0] a, input int n, input logic [7:0] v);
    logic [31:0] b;
    for (int k = 0; k < n; k++) begin
      b = a + k;
      chk({24'h0, rdq_mem_model_i.mem[b[11:2]][8*b[1:0] +: 8]}, {24'h0, v + k[7:0]});
    end
  endtask
  task automatic t_regs;
    chk({31'h0, irq}, 32'h0);
    rd_chk(rdq_pkg::REG_STATUS, 32'h0);
    rd_chk(rdq_pkg::REG_ENABLE, 32'h0);
    rd_chk(8'hFC, 32'h0);
    wr(rdq_pkg::REG_PTR_HI, 32'h40);
    rd_chk(rdq_pkg::REG_QUEUE, 32'h0);
    wr(rdq_pkg::REG_ENABLE, 32'h1);
    rd_chk(rdq_pkg::REG_ENABLE, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_basic;
    desc(32'h40, 32'h00020040, 32'h101, 16'd61, 32'h203, 16'd3);
    wr(rdq_pkg::REG_PTR_LO, 32'h40);
    send(64, 8'h10);
    wait_done();
    bytes_chk(32'h101, 61, 8'h10);
    bytes_chk(32'h203, 3, 8'h4D);
    bytes_chk(32'h100, 1, 8'hA5);
    bytes_chk(32'h206, 1, 8'hA5);
    chk(rdq_model_post(32'h40), 32'h00020040);
    chk({31'h0, irq}, 32'h1);
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    chk({31'h0, irq}, 32'h0);
    $display("test basic done");
  endtask
  function automatic logic [31:0] rdq_model_post(input logic [31:0] p);
    return rdq_mem_model_i.mem[p[11:2]];
  endfunction
  task automatic t_trunc;
    desc(32'h40, 32'h00020064, 32'h101, 16'd61, 32'h203, 16'd3);
    wr(rdq_pkg::REG_PTR_LO, 32'h40);
    send(70, 8'h20);
    wait_done();
    bytes_chk(32'h203, 3, 8'h5D);
    bytes_chk(32'h206, 1, 8'hA5);
    chk(rdq_model_post(32'h40), 32'h00020040);
    rd_chk(rdq_pkg::REG_STATUS, 32'h1);
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    $display("test trunc done");
  endtask
  task automatic t_ovf;
    desc(32'h40, 32'h00020040, 32'h101, 16'd61, 32'h203, 16'd9);
    wr(rdq_pkg::REG_PTR_LO, 32'h40);
    send(66, 8'h30);
    wait_done();
    bytes_chk(32'h206, 1, 8'hA5);
    chk(rdq_model_post(32'h40), 32'h08020040);
    rd_chk(rdq_pkg::REG_STATUS, 32'h5);
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    $display("test ovf done");
  endtask
  task automatic t_forced;
    wr(rdq_pkg::REG_ENABLE, 32'h0);
    desc(32'h40, 32'h80020040, 32'h101, 16'd61, 32'h203, 16'd3);
    wr(rdq_pkg::REG_PTR_LO, 32'h40);
    send(64, 8'h40);
    wait_done();
    chk({31'h0, irq}, 32'h1);
    rd_chk(rdq_pkg::REG_STATUS, 32'h3);
    rd_chk(rdq_pkg::REG_ENABLE, 32'h0);
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    chk({31'h0, irq}, 32'h0);
    desc(32'h40, 32'h00020040, 32'h101, 16'd61, 32'h203, 16'd3);
    wr(rdq_pkg::REG_PTR_LO, 32'h40);
    send(64, 8'h50);
    wait_done();
    chk({31'h0, irq}, 32'h0);
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    $display("test forced done");
  endtask
  task automatic t_queue;
    lat <= 4'h5;
    desc(32'h40, 32'h00010040, 32'h101, 16'd64, 32'h0, 16'd0);
    desc(32'h80, 32'h00010040, 32'h181, 16'd64, 32'h0, 16'd0);
    wr(rdq_pkg::REG_PTR_LO, 32'h40);
    wr(rdq_pkg::REG_PTR_LO, 32'h80);
    send(64, 8'h60);
    wait_done();
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    send(64, 8'h90);
    wait_done();
    bytes_chk(32'h101, 64, 8'h60);
    bytes_chk(32'h181, 64, 8'h90);
    chk(rdq_model_post(32'h40), 32'h00010040);
    chk(rdq_model_post(32'h80), 32'h00010040);
    rd_chk(rdq_pkg::REG_QUEUE, 32'h0);
    $display("test queue done");
  endtask
  // Engine held in a packet while the queue overruns, then a reset in mid-run
  task automatic t_full;
    wr(rdq_pkg::REG_CLEAR, 32'hF);
    wr(rdq_pkg::REG_ENABLE, 32'h8);
    repeat (rdq_pkg::FIFO_DEPTH + 2) wr(rdq_pkg::REG_PTR_LO, 32'h40);
    rd_chk(rdq_pkg::REG_QUEUE, {1'b1, 31'(rdq_pkg::FIFO_DEPTH)});
    rd_chk(rdq_pkg::REG_STATUS, 32'h8);
    chk({31'h0, irq}, 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(rdq_pkg::REG_QUEUE, 32'h0);
    rd_chk(rdq_pkg::REG_STATUS, 32'h0);
    rd_chk(rdq_pkg::REG_ENABLE, 32'h0);
    $display("test full done");
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_basic();
    t_trunc();
    t_ovf();
    t_forced();
    t_queue();
    t_full();
    finish_test();
  end
endmodule
`default_nettype wire
